// File: logic/cmgd_glue.sv
// Purpose: address latch and memory select decoder for the support chip
// Assumes: bus pins asynchronous to clk; clk much faster than bus clock
// Notes:   strobes lag the pins by the synchroniser delay plus one output register
// Function
// - a strap chooses support personality (high) or I/O personality (low).
// - every transfer is qualified by the microcontroller's bus clock.
// - the low address byte is on the shared lines while the strobe is high and is latched by it.
// - the latched byte drives the low address lines for the rest of the cycle.
// - all sixteen address bits are decoded so no location maps to more than one select.
// - memory output enable is low while bus clock and read-not-write are both high.
// - program chip enable is low when the address is in the program region.
// - SRAM chip enable is low when the address is in the SRAM region.
// - SRAM write enable is low while bus clock is high and read-not-write low.
// - the program region spans 32 K bytes and the SRAM region 8 K bytes.
`include "cmgd_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cmgd_glue #(
   parameter logic [15:0] ROM_BASE = `CMGD_ROM_BASE_DEF,
   parameter logic [15:0] RAM_BASE = `CMGD_RAM_BASE_DEF
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   // personality strap
   input  wire logic                 mode_strap,
   // microcontroller bus
   input  wire cmgd_pkg::cmgd_bus_s  bus_in,
   input  wire cmgd_pkg::cmgd_byte_t ad_in,
   // memory side
   output logic [7:0]                lo_addr,
   output cmgd_pkg::cmgd_sel_s       sel_out,
   output logic                      support_mode
);
   import cmgd_pkg::*;

   localparam int SW = 4 + `CMGD_DATA_W + `CMGD_DATA_W;

   logic [SW-1:0] pins_sync;
   logic          strap_e, clk_e, rnw_e, als_e;
   cmgd_byte_t    hi_e, ad_e;

   cmgd_sync #(.W(SW)) u_sync (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .pin_in    ({mode_strap, bus_in.bus_clk, bus_in.rd_nwr, bus_in.addr_latch_strobe, bus_in.hi_addr, ad_in}),
      .level_out (pins_sync)
   );

   assign {strap_e, clk_e, rnw_e, als_e, hi_e, ad_e} = pins_sync;

   // strap is a pin too: caught once, only after the synchroniser has settled
   logic [2:0] settle_q, settle_d;
   logic       strap_seen_q, strap_seen_d;
   logic       mode_q, mode_d;

   always_comb
   begin
      settle_d     = settle_q;
      strap_seen_d = strap_seen_q;
      mode_d       = mode_q;
      if (!strap_seen_q)
      begin
         if (settle_q == `CMGD_STRAP_SETTLE)
         begin
            strap_seen_d = 1'b1;
            mode_d       = strap_e;
         end
         else
            settle_d = settle_q + 3'h1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         settle_q     <= 3'h0;
         strap_seen_q <= 1'b0;
         mode_q       <= 1'b0;
      end
      else
      begin
         settle_q     <= settle_d;
         strap_seen_q <= strap_seen_d;
         mode_q       <= mode_d;
      end
   end

   wire logic active = strap_seen_q & (mode_q == `CMGD_MODE_SUPPORT);

   // address latch: transparent while strobe high, holds after
   cmgd_byte_t lo_q, lo_d;

   always_comb
   begin
      lo_d = lo_q;
      if (!active)
         lo_d = 8'h00;
      else if (als_e)
         lo_d = ad_e;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         lo_q <= 8'h00;
      else
         lo_q <= lo_d;
   end

   // decode
   cmgd_addr_t   full_addr;
   cmgd_region_e region;
   logic [16:0]  rom_off, ram_off;

   always_comb
   begin
      full_addr = {hi_e, lo_q};
      rom_off   = {1'b0, full_addr} - {1'b0, ROM_BASE};
      ram_off   = {1'b0, full_addr} - {1'b0, RAM_BASE};
      // rom checked first, so overlapping bases never give two selects
      if (!rom_off[16] && rom_off < `CMGD_ROM_SIZE)
         region = CMGD_REG_ROM;
      else if (!ram_off[16] && ram_off < `CMGD_RAM_SIZE)
         region = CMGD_REG_RAM;
      else
         region = CMGD_REG_NONE;
   end

   cmgd_sel_s sel_q, sel_d;

   always_comb
   begin
      sel_d = '{mem_oe_n: 1'b1, rom_ce_n: 1'b1, ram_ce_n: 1'b1, ram_we_n: 1'b1};
      if (active)
      begin
         case (region)
            CMGD_REG_ROM:  sel_d.rom_ce_n = 1'b0;
            CMGD_REG_RAM:  sel_d.ram_ce_n = 1'b0;
            CMGD_REG_NONE: sel_d.rom_ce_n = 1'b1;
            default:       sel_d.ram_ce_n = 1'b1;
         endcase
         sel_d.mem_oe_n = ~(clk_e & rnw_e);
         sel_d.ram_we_n = ~(clk_e & ~rnw_e);
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         sel_q <= '{mem_oe_n: 1'b1, rom_ce_n: 1'b1, ram_ce_n: 1'b1, ram_we_n: 1'b1};
      else
         sel_q <= sel_d;
   end

   assign sel_out      = sel_q;
   assign lo_addr      = lo_q;
   assign support_mode = active;

endmodule : cmgd_glue

`default_nettype wire

// File: logic/cmgd_defines.svh
// Purpose: constants for the memory glue decoder
// Assumes: 16-bit address space, 8-bit multiplexed low bus
// Notes:   timing counts are in cycles of clk (50 MHz)
`ifndef CMGD_DEFINES_SVH
`define CMGD_DEFINES_SVH

`define CMGD_ADDR_W        16
`define CMGD_DATA_W        8
`define CMGD_ROM_SIZE      17'h08000
`define CMGD_RAM_SIZE      17'h02000
`define CMGD_ROM_BASE_DEF  16'h8000
`define CMGD_RAM_BASE_DEF  16'h2000
`define CMGD_SYNC_STAGES   3
`define CMGD_STRAP_SETTLE  3'h4
`define CMGD_MODE_SUPPORT  1'b1

`endif

// File: logic/cmgd_pkg.sv
// Purpose: types for the memory glue decoder
// Assumes: cmgd_defines.svh holds the numbers
// Notes:   none
`include "cmgd_defines.svh"

package cmgd_pkg;

   typedef logic [`CMGD_ADDR_W-1:0] cmgd_addr_t;
   typedef logic [`CMGD_DATA_W-1:0] cmgd_byte_t;

   // bus pins from the microcontroller
   typedef struct packed {
      logic       bus_clk;
      logic       rd_nwr;
      logic       addr_latch_strobe;
      cmgd_byte_t hi_addr;
   } cmgd_bus_s;

   // memory strobes, all active low
   typedef struct packed {
      logic mem_oe_n;
      logic rom_ce_n;
      logic ram_ce_n;
      logic ram_we_n;
   } cmgd_sel_s;

   typedef enum logic [1:0] {
      CMGD_REG_NONE = 2'b00,
      CMGD_REG_ROM  = 2'b01,
      CMGD_REG_RAM  = 2'b10
   } cmgd_region_e;

endpackage : cmgd_pkg

// File: logic/cmgd_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes:   stage one is read only by stage two
`include "cmgd_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cmgd_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // pins in, filtered level out
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] level_out
);

   logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [W-1:0] s1_d, s2_d, s3_d, lvl_d;

   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         // a change counts only once stages two and three agree
         always_comb
         begin
            s1_d[g]  = pin_in[g];
            s2_d[g]  = s1_q[g];
            s3_d[g]  = s2_q[g];
            lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         lvl_q <= '0;
      end
      else
      begin
         s1_q  <= s1_d;
         s2_q  <= s2_d;
         s3_q  <= s3_d;
         lvl_q <= lvl_d;
      end
   end

   assign level_out = lvl_q;

endmodule : cmgd_sync

`default_nettype wire

// File: tb/cmgd_glue_asserts.sv
// Purpose: port checks for the glue decoder
// Assumes: strobes settle 5 clk after pins
// Notes:   8 clk windows leave margin
`timescale 1ns/1ps
`default_nettype none
module cmgd_glue_asserts
   import cmgd_pkg::*;
#(
   parameter logic [15:0] ROM_BASE = 16'h8000,
   parameter logic [15:0] RAM_BASE = 16'h2000
) (
   // clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // watched ports
   input wire cmgd_bus_s  bus_in,
   input wire cmgd_byte_t ad_in,
   input wire logic [7:0] lo_addr,
   input wire cmgd_sel_s  sel_out,
   input wire logic       support_mode
);
   wire logic       m = support_mode;
   wire logic       e = bus_in.bus_clk;
   wire logic       w = bus_in.rd_nwr;
   wire logic       s = bus_in.addr_latch_strobe;
   wire cmgd_addr_t ro = {bus_in.hi_addr, lo_addr} - ROM_BASE;
   wire cmgd_addr_t ra = {bus_in.hi_addr, lo_addr} - RAM_BASE;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_oe_read: assert property ((m && e && w)[*8] |-> !sel_out.mem_oe_n)
      else $error("no read oe");
   a_oe_idle: assert property ((!e)[*8] |-> sel_out.mem_oe_n)
      else $error("stray oe");
   a_we_write: assert property ((m && e && !w)[*8] |-> !sel_out.ram_we_n)
      else $error("no write we");
   a_lo_latch: assert property ((m && s && $stable(ad_in))[*8] |-> lo_addr == ad_in)
      else $error("byte not latched");
   a_lo_hold: assert property ((m && !s)[*8] |-> $stable(lo_addr))
      else $error("byte moved");
   a_rom_dec: assert property ((m && $stable(ro))[*8] |-> sel_out.rom_ce_n == (ro > 16'h7FFF))
      else $error("rom select");
   // overlap gives the rom region priority
   a_ram_dec: assert property ((m && $stable(ra))[*8] |-> sel_out.ram_ce_n == (ro < 16'h8000 || ra > 16'h1FFF))
      else $error("ram select");
   a_io_quiet: assert property (!m |-> sel_out == 4'hF && lo_addr == 8'h00)
      else $error("io mode select");
endmodule : cmgd_glue_asserts
`default_nettype wire

// File: tb/cmgd_mcu_model.sv
// Purpose: microcontroller bus model
// Assumes: bus clock high for 12 clk of a 48 clk cycle
// Notes:   freed data lines show inverted address
`timescale 1ns/1ps
`default_nettype none
module cmgd_mcu_model
   import cmgd_pkg::*;
(
   // clock, request {rd, addr} held to done
   input wire logic        clk,
   input wire logic        go,
   input wire logic [16:0] req,
   // bus pins
   output cmgd_bus_s       bus_in,
   output cmgd_byte_t      ad_in,
   output logic            done
);
   logic [5:0] cnt_q = 6'h00;
   assign done = cnt_q == 6'h2F;
   always @(posedge clk)
      if (go || cnt_q != 6'h00)
         cnt_q <= done ? 6'h00 : cnt_q + 6'h01;
   always_comb
   begin
      bus_in.addr_latch_strobe = cnt_q inside {[1:12]};
      bus_in.bus_clk = cnt_q inside {[25:36]};
      bus_in.rd_nwr = req[16] || cnt_q < 6'h0D;
      bus_in.hi_addr = req[15:8];
      ad_in = cnt_q inside {[1:12]} ? req[7:0] : ~req[7:0];
   end
endmodule : cmgd_mcu_model
`default_nettype wire

// File: tb/cmgd_glue_tb.sv
// Purpose: bench for the glue decoder
// Assumes: default region bases
// Notes:   decode rows, then I/O mode
`timescale 1ns/1ps
`default_nettype none
module cmgd_glue_tb;
   import cmgd_pkg::*;
   logic        clk = 1'b0, sys_rst = 1'b1, strap = 1'b1, go = 1'b0, done, sm;
   logic [16:0] req = 17'h00000;
   cmgd_bus_s   bus;
   cmgd_byte_t  ad, lo;
   cmgd_sel_s   sel;
   int          errors = 0, cmp_count = 0, cyc = 0;
   // {0, rd, rom_ce_n, ram_ce_n, address}
   logic [19:0] rows [8] = '{20'h58123, 20'h1FFFF, 20'h77FFF, 20'h22000,
                             20'h63FFF, 20'h34000, 20'h71FFF, 20'h30000};
   cmgd_glue i_dut (.clk(clk), .sys_rst(sys_rst), .mode_strap(strap), .bus_in(bus), .ad_in(ad),
                    .lo_addr(lo), .sel_out(sel), .support_mode(sm));
   cmgd_mcu_model i_mcu (.clk(clk), .go(go), .req(req), .bus_in(bus), .ad_in(ad), .done(done));
   initial
      forever #10 clk = ~clk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h not %h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("errors %0d of %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   task automatic rst(input logic s);
      @(posedge clk);
      sys_rst <= 1'b1;
      strap <= s;
      repeat (4) @(posedge clk);
      #1 chk(sel, 8'h0F);
      @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
      #1 chk(sm, s);
   endtask : rst
   // one whole bus cycle, strobes checked mid data phase
   task automatic op(input logic [19:0] r, input logic io);
      @(posedge clk);
      req <= {r[18], r[15:0]};
      go <= 1'b1;
      repeat (33) @(posedge clk);
      #1 chk(sel.mem_oe_n, !r[18] | io);
      chk(sel.ram_we_n, r[18] | io);
      chk(sel.rom_ce_n, r[17] | io);
      chk(sel.ram_ce_n, r[16] | io);
      chk(lo, io ? 8'h00 : r[7:0]);
      while (done !== 1'b1)
         @(posedge clk);
      go <= 1'b0;
   endtask : op
   initial
   begin
      rst(1'b1);
      foreach (rows[i])
         op(rows[i], 1'b0);
      rst(1'b0);
      op(20'h22000, 1'b1);
      close_out();
   end
   always @(posedge clk)
      if (++cyc == 2000)
      begin
         errors++;
         close_out();
      end
endmodule : cmgd_glue_tb
bind cmgd_glue cmgd_glue_asserts #(.ROM_BASE(ROM_BASE), .RAM_BASE(RAM_BASE)) i_chk (.clk(clk), .sys_rst(sys_rst),
   .bus_in(bus_in), .ad_in(ad_in), .lo_addr(lo_addr), .sel_out(sel_out), .support_mode(support_mode));
`default_nettype wire
